// file: bench/comp_model.sv
`timescale 1ns/1ns
module comp_model (
    // converter side
    input wire logic [11:0] dac_ref,
    input wire logic mux_sel,
    input wire logic amp_gnd,
    // analog levels
    input wire logic [11:0] lvl_inc,
    input wire logic [11:0] lvl_refl,
    input wire logic [11:0] lvl_zero,
    // decision
    output logic comp
);
    logic [11:0] lvl;
    assign lvl = amp_gnd ? lvl_zero : (mux_sel ? lvl_refl : lvl_inc);
    assign comp = (lvl >= dac_ref);
endmodule : comp_model

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic ack, comp, mux, gnd, pdn, sup, init, wflag, aoff, irq, ledm, ledr;
    logic mains_n = 1'b0, key = 1'b0, rcmd = 1'b0;
    logic [11:0] dac;
    logic [1:0] rng;
    logic [15:0] rec;
    logic [11:0] lv_inc = 12'h5a3, lv_refl = 12'h3c1, lv_zero = 12'h010;
    int bad_count = 0, n_tests = 0, cycles = 0;
    sar_measure_power_cycle_ctrl #(.ON_DELAY_CYC(40'd20),
        .STOP_CYC(40'd50), .PULSE_CYC(40'd10), .CODE_CYC(40'd30),
        .AUTO_OFF_CYC(40'd2000))
    sar_measure_power_cycle_ctrl_i (.CLOCK(clk), .RST(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .COMP_IN(comp), .DAC_REF(dac), .MUX_SEL(mux), .AMP_GND(gnd),
        .RANGE(rng), .REC_DAC(rec), .MAINS_UNIT_FITTED_N(mains_n),
        .KEY_WAKE(key), .REMOTE_CMD(rcmd), .POWER_DOWN_N(pdn),
        .SUPPLY_ENABLE(sup), .CPU_INIT_PULSE(init),
        .WAKE_FROM_STOP_FLAG(wflag), .AUTO_OFF_REQUEST(aoff),
        .CPU_IRQ(irq), .LED_MAINS(ledm), .LED_REMOTE(ledr));
    comp_model comp_model_i (.dac_ref(dac), .mux_sel(mux), .amp_gnd(gnd),
        .lvl_inc(lv_inc), .lvl_refl(lv_refl), .lvl_zero(lv_zero),
        .comp(comp));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1) bad_count++;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic t_reset();
        int n;
        chk({pdn, sup, init, gnd, rng, wflag, aoff}, 8'h78);
        for (n = 0; n < 40 && init !== 1'b0; n++) @(posedge clk);
        chk(n >= 20 && n <= 23, 1);
    endtask : t_reset
    task automatic t_meas();
        int n;
        logic m;
        logic [31:0] q;
        wb(1'b1, 8'h08, 32'h64, q);
        for (n = 0; n < 40000 && gnd !== 1'b0; n++) @(posedge clk);
        chk(gnd, 0);
        m = mux;
        for (n = 0; n < 4000 && mux === m; n++) @(posedge clk);
        m = mux;
        for (n = 0; n < 4000 && mux === m; n++) @(posedge clk);
        chk(n > 3000 && n < 3200, 1);
        repeat (7000) @(posedge clk);
        chk(rec, 16'h0593);
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h03b1);
        chk(rng, 2'h2);
        lv_inc <= 12'h050;
        wb(1'b1, 8'h00, 32'h0d, q);
        chk(mux, 0);
        repeat (6200) @(posedge clk);
        wb(1'b0, 8'h04, 32'h0, q);
        chk(q[1:0], 0);
        chk(rng, 2'h1);
        wb(1'b1, 8'h00, 32'h0d, q);
        repeat (6200) @(posedge clk);
        chk(rng, 2'h0);
        wb(1'b1, 8'h00, 32'h11, q);
        repeat (2) @(posedge clk);
        chk({gnd, rng}, 3'h4);
    endtask : t_meas
    task automatic t_irq();
        logic [31:0] q;
        wb(1'b0, 8'h00, 32'h0, q);
        chk(q, 32'h01);
        wb(1'b1, 8'h00, 32'h21, q);
        rcmd <= 1'b1;
        repeat (6) @(posedge clk);
        chk({irq, ledm, ledr}, 3'h7);
        wb(1'b1, 8'h18, 32'h3, q);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        rcmd <= 1'b0;
    endtask : t_irq
    task automatic t_power();
        int n;
        logic [31:0] q;
        wb(1'b1, 8'h1c, 32'h3, q);
        repeat (60) @(posedge clk);
        chk(sup, 1);
        mains_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(wflag, 0);
        wb(1'b1, 8'h1c, 32'h3, q);
        for (n = 0; n < 20 && sup !== 1'b0; n++) @(posedge clk);
        chk(sup, 0);
        for (n = 0; n < 80 && sup !== 1'b1; n++) @(posedge clk);
        chk(n >= 45 && n <= 55 && init === 1'b1, 1);
        for (n = 0; n < 30 && init !== 1'b0; n++) @(posedge clk);
        chk(n >= 8 && n <= 13 && wflag === 1'b1, 1);
        wb(1'b1, 8'h1c, 32'h3, q);
        for (n = 0; n < 20 && sup !== 1'b0; n++) @(posedge clk);
        key <= 1'b1;
        for (n = 0; n < 40 && sup !== 1'b1; n++) @(posedge clk);
        chk(n < 10, 1);
        key <= 1'b0;
        for (n = 0; n < 2500 && aoff !== 1'b1; n++) @(posedge clk);
        chk({aoff, pdn}, 2'h3);
    endtask : t_power
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_meas();
        t_irq();
        t_power();
        conclude();
    end
endmodule : tb

// file: verilog/sar_ctrl_map.svh
`ifndef SAR_CTRL_MAP_SVH
`define SAR_CTRL_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SCALE 8'h08
`define REG_RES_INC 8'h0c
`define REG_RES_REFL 8'h10
`define REG_RAW 8'h14
`define REG_INT_SRC 8'h18
`define REG_CYCLE 8'h1c
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_START_BIT 3
`define CTRL_ZCAL_BIT 4
`define CYC_DONE_BIT 0
`define CYC_DISP_BIT 1
`define CTRL_RESET 8'h01
`define SCALE_RESET 16'h0001
`define UP_THR 12'he00
`define DN_THR 12'h0c0
`define SAR_FIRST 12'h800
`define RANGE_TOP 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ 64'd125000
`define ON_DELAY_MS 10
`define STOP_MS 400
`define INIT_PULSE_MS 1
`define CODE_SHOW_MS 1000
`define AUTO_OFF_MIN 30
`define OFFSET_PERIOD_MIN_X10 33
`define SETTLE_NS 2000
`define SETTLE_CYC 9'((`SETTLE_NS * `CLK_KHZ + 64'd999999) / 64'd1000000)
`define DIV_STEPS 5'd20
`endif

// file: verilog/sar_ctrl_pkg.sv
package sar_ctrl_pkg;
    // ------------------------------------------------------------
    // states and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        P_ON_DLY, P_RUN, P_STOP, P_WAKE, P_OFF
    } pwr_state_t;
    typedef enum logic [2:0] {
        M_INIT, M_IDLE, M_SETTLE, M_BIT, M_DIV, M_DONE
    } meas_state_t;
    typedef struct packed {
        logic [1:0] range;
        logic remote;
        logic zcal;
        logic start;
        logic trig;
        logic hold;
        logic run;
    } ctrl_t;
    typedef struct packed {
        logic remote;
        logic mains_n;
        logic key;
        logic comp;
    } pins_t;
endpackage : sar_ctrl_pkg

// file: verilog/sar_measure_power_cycle_ctrl.sv
// Function
// - alternate incident and reflected into comparator
// - 12-bit reference converter code set here
// - conversion decides all twelve bits
// - subtract offset, divide by K, range scale
// - corrected incident value drives recorder converter
// - switch-on: supply on, reset after delay
// - battery: power off 400 ms per cycle
// - stop expiry: power on, 1 ms reset
// - wake flag low after on, high after stop
// - key press ends stop interval at once
// - mains: never duty-cycle the processor
// - battery: auto-off after 30 idle minutes
// - init: ground input, range 2, 1 s
// - then store offsets, three ranges, both channels
// - re-measure offsets every 3.3 minutes
// - autorange unless range hold
// - start command aborts and restarts measurement, except during init and any offset measurement, including the first one after init
// - key and remote raise processor interrupt
// - mains led, remote led additionally
`timescale 1ns/1ns
`include "sar_ctrl_map.svh"
module sar_measure_power_cycle_ctrl #(
    parameter logic [39:0] ON_DELAY_CYC = 40'(`ON_DELAY_MS * `CLK_KHZ),
    parameter logic [39:0] STOP_CYC = 40'(`STOP_MS * `CLK_KHZ),
    parameter logic [39:0] PULSE_CYC = 40'(`INIT_PULSE_MS * `CLK_KHZ),
    parameter logic [39:0] CODE_CYC = 40'(`CODE_SHOW_MS * `CLK_KHZ),
    parameter logic [39:0] AUTO_OFF_CYC =
        40'(`AUTO_OFF_MIN * 64'd60000 * `CLK_KHZ),
    parameter logic [39:0] OFFSET_CYC =
        40'(`OFFSET_PERIOD_MIN_X10 * 64'd6000 * `CLK_KHZ)
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // analog front end
    input wire logic COMP_IN,
    output logic [11:0] DAC_REF,
    output logic MUX_SEL,
    output logic AMP_GND,
    output logic [1:0] RANGE,
    output logic [15:0] REC_DAC,
    // power control pins
    input wire logic MAINS_UNIT_FITTED_N,
    input wire logic KEY_WAKE,
    input wire logic REMOTE_CMD,
    output logic POWER_DOWN_N,
    output logic SUPPLY_ENABLE,
    output logic CPU_INIT_PULSE,
    output logic WAKE_FROM_STOP_FLAG,
    output logic AUTO_OFF_REQUEST,
    output logic CPU_IRQ,
    // indicators
    output logic LED_MAINS,
    output logic LED_REMOTE
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge
    function automatic logic [2:0] oidx(input logic [1:0] rng,
        input logic ch);
        return {rng, 1'b0} + {2'h0, ch};
    endfunction : oidx
    function automatic logic [6:0] mult(input logic [1:0] rng);
        return (rng == 2'h0) ? 7'd1 : (rng == 2'h1) ? 7'd10 : 7'd100;
    endfunction : mult
    function automatic logic [15:0] sat16(input logic [19:0] v);
        return (v[19:16] != 4'h0) ? 16'hffff : v[15:0];
    endfunction : sat16
    function automatic logic [11:0] bitm(input logic [3:0] b);
        return 12'h001 << b;
    endfunction : bitm

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sar_ctrl_pkg::pins_t s1_q, s2_q, s3_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {REMOTE_CMD, MAINS_UNIT_FITTED_N, KEY_WAKE, COMP_IN};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic battery, key_rise, rem_rise;
    assign battery = s2_q.mains_n;
    assign key_rise = s2_q.key & ~s3_q.key;
    assign rem_rise = s2_q.remote & ~s3_q.remote;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_q, acc, wr;
    logic [31:0] dat_q, rd_d;
    sar_ctrl_pkg::ctrl_t ctrl_q;
    logic [15:0] scale_q, rec_q;
    logic [15:0] res_q [2];
    logic [11:0] code_q, dac_q;
    logic [1:0] int_q, rng_q;
    logic ch_q, zcal_q, wake_q, aoff_q;
    sar_ctrl_pkg::meas_state_t m_q;
    sar_ctrl_pkg::pwr_state_t pwr_q;
    assign acc = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr = acc & WB_WE_I;
    logic wr_ctrl, start_wr, zcal_wr, done_wr, disp_wr;
    assign wr_ctrl = wr && WB_ADR_I == `REG_CTRL && WB_SEL_I[0];
    assign start_wr = wr_ctrl && WB_DAT_I[`CTRL_START_BIT];
    assign zcal_wr = wr_ctrl && WB_DAT_I[`CTRL_ZCAL_BIT];
    assign done_wr = wr && WB_ADR_I == `REG_CYCLE && WB_SEL_I[0]
        && WB_DAT_I[`CYC_DONE_BIT];
    assign disp_wr = wr && WB_ADR_I == `REG_CYCLE && WB_SEL_I[0]
        && WB_DAT_I[`CYC_DISP_BIT];
    always_comb begin
        unique case (WB_ADR_I)
            `REG_CTRL: rd_d = {24'h0, ctrl_q};
            `REG_STATUS: rd_d = {24'h0, aoff_q, ~battery, wake_q, zcal_q,
                rng_q, ch_q, m_q != sar_ctrl_pkg::M_IDLE};
            `REG_SCALE: rd_d = {16'h0, scale_q};
            `REG_RES_INC: rd_d = {16'h0, res_q[0]};
            `REG_RES_REFL: rd_d = {16'h0, res_q[1]};
            `REG_RAW: rd_d = {20'h0, code_q};
            `REG_INT_SRC: rd_d = {30'h0, int_q};
            default: rd_d = 32'h0;
        endcase
    end
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            if (acc) begin
                dat_q <= rd_d;
            end
        end
    end
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_q <= `CTRL_RESET;
            scale_q <= `SCALE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= 8'(WB_DAT_I) & 8'he7;
            end
            if (wr && WB_ADR_I == `REG_SCALE) begin
                scale_q <= 16'(merge({16'h0, scale_q}, WB_DAT_I, WB_SEL_I));
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt sources, write one to clear, set wins
    // ------------------------------------------------------------
    logic [1:0] clr;
    assign clr = (wr && WB_ADR_I == `REG_INT_SRC && WB_SEL_I[0]) ?
        WB_DAT_I[1:0] : 2'h0;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            int_q <= 2'h0;
        end else begin
            int_q <= (int_q & ~clr) | {rem_rise, key_rise};
        end
    end

    // ------------------------------------------------------------
    // offset recalibration timer
    // ------------------------------------------------------------
    logic [39:0] ofs_cnt_q;
    logic zpend_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ofs_cnt_q <= 40'h0;
            zpend_q <= 1'b0;
        end else begin
            ofs_cnt_q <= (ofs_cnt_q >= OFFSET_CYC - 40'h1) ? 40'h0 :
                ofs_cnt_q + 40'h1;
            zpend_q <= zcal_wr || ofs_cnt_q >= OFFSET_CYC - 40'h1
                || (zpend_q && m_q != sar_ctrl_pkg::M_IDLE);
        end
    end

    // ------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------
    logic [11:0] offs_q [6];
    logic [3:0] bit_q;
    logic [8:0] set_q;
    logic [1:0] zrng_q;
    logic [19:0] num_q;
    logic [16:0] rem_q, rt;
    logic [4:0] dcnt_q;
    logic [39:0] icnt_q;
    logic amp_gnd_q, arm_q;
    logic [11:0] kept, diff;
    assign kept = s2_q.comp ? dac_q : dac_q & ~bitm(bit_q);
    assign diff = (kept > offs_q[oidx(rng_q, ch_q)]) ?
        kept - offs_q[oidx(rng_q, ch_q)] : 12'h0;
    assign rt = {rem_q[15:0], num_q[19]};
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            m_q <= sar_ctrl_pkg::M_INIT;
            amp_gnd_q <= 1'b1;
            rng_q <= `RANGE_TOP;
            zrng_q <= 2'h0;
            zcal_q <= 1'b0;
            ch_q <= 1'b0;
            arm_q <= 1'b0;
            dac_q <= 12'h0;
            code_q <= 12'h0;
            bit_q <= 4'h0;
            set_q <= 9'h0;
            num_q <= 20'h0;
            rem_q <= 17'h0;
            dcnt_q <= 5'h0;
            icnt_q <= 40'h0;
            res_q[0] <= 16'h0;
            res_q[1] <= 16'h0;
            rec_q <= 16'h0;
            for (int i = 0; i < 6; i++) begin
                offs_q[i] <= 12'h0;
            end
        end else if (start_wr && !zcal_q && m_q != sar_ctrl_pkg::M_INIT)
        begin
            ch_q <= 1'b0;
            arm_q <= 1'b1;
            m_q <= sar_ctrl_pkg::M_SETTLE;
        end else begin
            unique case (m_q)
                sar_ctrl_pkg::M_INIT: begin
                    icnt_q <= icnt_q + 40'h1;
                    if (icnt_q >= CODE_CYC - 40'h1) begin
                        zcal_q <= 1'b1;
                        zrng_q <= 2'h0;
                        ch_q <= 1'b0;
                        m_q <= sar_ctrl_pkg::M_SETTLE;
                    end
                end
                sar_ctrl_pkg::M_IDLE: begin
                    if (zpend_q) begin
                        zcal_q <= 1'b1;
                        amp_gnd_q <= 1'b1;
                        zrng_q <= 2'h0;
                        ch_q <= 1'b0;
                        m_q <= sar_ctrl_pkg::M_SETTLE;
                    end else if (ctrl_q.run && (!ctrl_q.trig || arm_q)) begin
                        m_q <= sar_ctrl_pkg::M_SETTLE;
                    end
                end
                sar_ctrl_pkg::M_SETTLE: begin
                    dac_q <= `SAR_FIRST;
                    bit_q <= 4'd11;
                    set_q <= `SETTLE_CYC;
                    m_q <= sar_ctrl_pkg::M_BIT;
                end
                sar_ctrl_pkg::M_BIT: begin
                    if (set_q != 9'h0) begin
                        set_q <= set_q - 9'h1;
                    end else if (bit_q != 4'h0) begin
                        dac_q <= kept | bitm(bit_q - 4'h1);
                        bit_q <= bit_q - 4'h1;
                        set_q <= `SETTLE_CYC;
                    end else if (zcal_q) begin
                        dac_q <= kept;
                        offs_q[oidx(zrng_q, ch_q)] <= kept;
                        ch_q <= ~ch_q;
                        if (ch_q) begin
                            zrng_q <= zrng_q + 2'h1;
                        end
                        if (ch_q && zrng_q == `RANGE_TOP) begin
                            zcal_q <= 1'b0;
                            amp_gnd_q <= 1'b0;
                            m_q <= sar_ctrl_pkg::M_IDLE;
                        end else begin
                            m_q <= sar_ctrl_pkg::M_SETTLE;
                        end
                    end else begin
                        dac_q <= kept;
                        code_q <= kept;
                        num_q <= 20'(diff * mult(rng_q));
                        rem_q <= 17'h0;
                        dcnt_q <= `DIV_STEPS;
                        m_q <= sar_ctrl_pkg::M_DIV;
                        if (ctrl_q.hold) begin
                            rng_q <= (ctrl_q.range > `RANGE_TOP) ?
                                `RANGE_TOP : ctrl_q.range;
                        end else if (kept >= `UP_THR && rng_q != `RANGE_TOP)
                        begin
                            rng_q <= rng_q + 2'h1;
                        end else if (kept < `DN_THR && rng_q != 2'h0) begin
                            rng_q <= rng_q - 2'h1;
                        end
                    end
                end
                sar_ctrl_pkg::M_DIV: begin
                    if (rt >= {1'b0, scale_q}) begin
                        rem_q <= rt - {1'b0, scale_q};
                        num_q <= {num_q[18:0], 1'b1};
                    end else begin
                        rem_q <= rt;
                        num_q <= {num_q[18:0], 1'b0};
                    end
                    dcnt_q <= dcnt_q - 5'h1;
                    if (dcnt_q == 5'h1) begin
                        m_q <= sar_ctrl_pkg::M_DONE;
                    end
                end
                sar_ctrl_pkg::M_DONE: begin
                    res_q[ch_q] <= sat16(num_q);
                    if (!ch_q) begin
                        rec_q <= sat16(num_q);
                    end else begin
                        arm_q <= 1'b0;
                    end
                    ch_q <= ~ch_q;
                    m_q <= sar_ctrl_pkg::M_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power cycling
    // ------------------------------------------------------------
    logic [39:0] pcnt_q, aoff_cnt_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            aoff_cnt_q <= 40'h0;
        end else if (!battery || disp_wr) begin
            aoff_cnt_q <= 40'h0;
        end else if (aoff_cnt_q != AUTO_OFF_CYC) begin
            aoff_cnt_q <= aoff_cnt_q + 40'h1;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pwr_q <= sar_ctrl_pkg::P_ON_DLY;
            pcnt_q <= 40'h0;
        end else begin
            unique case (pwr_q)
                sar_ctrl_pkg::P_ON_DLY: begin
                    pcnt_q <= pcnt_q + 40'h1;
                    if (pcnt_q >= ON_DELAY_CYC - 40'h1) begin
                        pwr_q <= sar_ctrl_pkg::P_RUN;
                        pcnt_q <= 40'h0;
                    end
                end
                sar_ctrl_pkg::P_RUN: begin
                    pcnt_q <= 40'h0;
                    if (aoff_cnt_q == AUTO_OFF_CYC) begin
                        pwr_q <= sar_ctrl_pkg::P_OFF;
                    end else if (done_wr && battery) begin
                        pwr_q <= sar_ctrl_pkg::P_STOP;
                    end
                end
                sar_ctrl_pkg::P_STOP: begin
                    pcnt_q <= pcnt_q + 40'h1;
                    if (s2_q.key || pcnt_q >= STOP_CYC - 40'h1) begin
                        pwr_q <= sar_ctrl_pkg::P_WAKE;
                        pcnt_q <= 40'h0;
                    end
                end
                sar_ctrl_pkg::P_WAKE: begin
                    pcnt_q <= pcnt_q + 40'h1;
                    if (pcnt_q >= PULSE_CYC - 40'h1) begin
                        pwr_q <= sar_ctrl_pkg::P_RUN;
                        pcnt_q <= 40'h0;
                    end
                end
                sar_ctrl_pkg::P_OFF: begin
                    pcnt_q <= 40'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic pdn_q, sup_q, init_q, irq_q, ledm_q, ledr_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pdn_q <= 1'b0;
            sup_q <= 1'b1;
            init_q <= 1'b1;
            wake_q <= 1'b0;
            aoff_q <= 1'b0;
            irq_q <= 1'b0;
            ledm_q <= 1'b0;
            ledr_q <= 1'b0;
        end else begin
            pdn_q <= pwr_q == sar_ctrl_pkg::P_OFF;
            sup_q <= pwr_q != sar_ctrl_pkg::P_STOP
                && pwr_q != sar_ctrl_pkg::P_OFF;
            init_q <= pwr_q == sar_ctrl_pkg::P_ON_DLY
                || pwr_q == sar_ctrl_pkg::P_WAKE;
            wake_q <= wake_q || pwr_q == sar_ctrl_pkg::P_STOP;
            aoff_q <= pwr_q == sar_ctrl_pkg::P_OFF;
            irq_q <= |int_q;
            ledm_q <= ~battery;
            ledr_q <= ~battery & ctrl_q.remote;
        end
    end
    assign WB_DAT_O = dat_q;
    assign WB_ACK_O = ack_q;
    assign DAC_REF = dac_q;
    assign MUX_SEL = ch_q;
    assign AMP_GND = amp_gnd_q;
    assign RANGE = zcal_q ? zrng_q : rng_q;
    assign REC_DAC = rec_q;
    assign POWER_DOWN_N = pdn_q;
    assign SUPPLY_ENABLE = sup_q;
    assign CPU_INIT_PULSE = init_q;
    assign WAKE_FROM_STOP_FLAG = wake_q;
    assign AUTO_OFF_REQUEST = aoff_q;
    assign CPU_IRQ = irq_q;
    assign LED_MAINS = ledm_q;
    assign LED_REMOTE = ledr_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    property p_sar_keep;
        m_q == sar_ctrl_pkg::M_BIT && set_q == 9'h0 && !start_wr
            && bit_q != 4'h0 |=> dac_q[$past(bit_q)] == $past(s2_q.comp);
    endproperty
    a_sar_keep: assert property (p_sar_keep)
        else $error("sar bit not decided by comparator");
    property p_alternate;
        m_q == sar_ctrl_pkg::M_DONE && !start_wr |=> ch_q != $past(ch_q);
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("channel did not alternate");
    property p_stop_off;
        pwr_q == sar_ctrl_pkg::P_STOP |=> !SUPPLY_ENABLE;
    endproperty
    a_stop_off: assert property (p_stop_off)
        else $error("supply on during stop");
    property p_mains_run;
        pwr_q == sar_ctrl_pkg::P_RUN && !battery && done_wr
            |=> pwr_q == sar_ctrl_pkg::P_RUN;
    endproperty
    a_mains_run: assert property (p_mains_run)
        else $error("mains unit entered stop");
    property p_key_wake;
        pwr_q == sar_ctrl_pkg::P_STOP && s2_q.key
            |=> pwr_q == sar_ctrl_pkg::P_WAKE ##1 CPU_INIT_PULSE;
    endproperty
    a_key_wake: assert property (p_key_wake)
        else $error("key did not end stop");
    property p_wake_flag;
        pwr_q == sar_ctrl_pkg::P_STOP |=> ##[0:1] WAKE_FROM_STOP_FLAG;
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake flag not set after stop");
    property p_auto_off;
        pwr_q == sar_ctrl_pkg::P_OFF |=> AUTO_OFF_REQUEST && POWER_DOWN_N;
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("auto off not signalled");
    property p_irq;
        key_rise |=> int_q[0] ##1 CPU_IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("key interrupt lost");
    property p_leds;
        LED_REMOTE |-> LED_MAINS;
    endproperty
    a_leds: assert property (p_leds)
        else $error("remote led without mains led");
    property p_restart;
        start_wr && !zcal_q && m_q != sar_ctrl_pkg::M_INIT
            |=> m_q == sar_ctrl_pkg::M_SETTLE && !ch_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("start did not restart measurement");
endmodule : sar_measure_power_cycle_ctrl
